// ===== rtl/spk_pkg.sv
// constants, types and shared arithmetic for the speakerphone decision block
package spk_pkg;

  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTL0 = 8'h00;
  localparam logic [7:0] ADDR_CTL1 = 8'h04;
  localparam logic [7:0] ADDR_CTL2 = 8'h08;
  localparam logic [7:0] ADDR_CTL3 = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_LEVELS = 8'h14;
  localparam logic [15:0] CTL0_RST = 16'h0A00;
  localparam logic [15:0] CTL1_RST = 16'h0A00;
  localparam logic [15:0] CTL2_RST = 16'h0000;
  localparam logic [15:0] CTL3_RST = 16'h0000;
  localparam int CTL0_IDLE_RET_BIT = 0;
  localparam int CTL0_POLICY_BIT = 4;
  localparam int VOL_LSB = 8;
  localparam int CTL1_TX_THR_LSB = 14;
  localparam int CTL2_RX_THR_LSB = 14;
  localparam int CTL2_RSQ_THR_LSB = 12;
  localparam int CTL2_RAMP_LSB = 10;
  localparam int CTL2_HOLD_LSB = 8;
  localparam int CTL3_TX_SQUELCH_ATTENUATION_LSB = 14;
  localparam int CTL3_ERLE_LSB = 6;
  localparam int CTL3_BIAS_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------------------
  // levels in 3 dB units, timing in samples
  // --------------------------------------------------------------------------
  localparam int DB_STEP = 3;
  localparam int THR_BASE_DB = 6;
  localparam int TX_SQ_THR_DB = 6;
  localparam int ERLE_BASE_DB = 15;
  localparam int BIAS_BASE_DB = 18;
  localparam int RX_SQ_DB = 24;
  localparam int GAIN_MAX_DB = 30;
  localparam logic [4:0] THR_BASE_U = 5'(THR_BASE_DB / DB_STEP);
  localparam logic [4:0] TX_SQ_THR_U = 5'(TX_SQ_THR_DB / DB_STEP);
  localparam logic [5:0] ERLE_BASE_U = 6'(ERLE_BASE_DB / DB_STEP);
  localparam logic [5:0] BIAS_BASE_U = 6'(BIAS_BASE_DB / DB_STEP);
  localparam logic [5:0] RX_SQ_U = 6'(RX_SQ_DB / DB_STEP);
  localparam logic [5:0] GAIN_MAX_U = 6'(GAIN_MAX_DB / DB_STEP);
  localparam logic [4:0] LVL_FS = 5'h1D;
  localparam logic [3:0] VOL_MUTE = 4'hF;
  localparam int SAMPLE_HZ = 8000;
  localparam int ATTACK_US = 125;
  localparam int DECAY_MS = 30;
  localparam int ATTACK_SMP = (ATTACK_US * SAMPLE_HZ + 999999) / 1000000;
  localparam logic [7:0] DECAY_SMP = 8'(DECAY_MS * SAMPLE_HZ / 1000);
  localparam int HOLD_MS [4] = '{50, 100, 200, 400};
  localparam int RAMP_MS [4] = '{32, 64, 128, 256};

  typedef enum logic [2:0] {
    HD_IDLE = 3'b001,
    HD_TX = 3'b010,
    HD_RX = 3'b100
  } spk_hd_type;

  // --------------------------------------------------------------------------
  // log level of a sample: two units per octave, so one unit is 3 dB
  // --------------------------------------------------------------------------
  function automatic logic [4:0] spk_level(input logic [15:0] x);
    logic [15:0] a;
    logic [4:0] l;
    a = x[15] ? 16'(-x) : x;
    l = 5'h00;
    for (int i = 1; i < 16; i++) begin
      if (a[i]) begin
        l = 5'(2 * i) + {4'h0, a[i-1]};
      end
    end
    return l;
  endfunction

  // gain in 3 dB steps: odd steps use 181/128 as root two
  function automatic logic [15:0] spk_scale(input logic [15:0] x, input logic signed [6:0] net);
    logic signed [31:0] p;
    logic signed [6:0] sh;
    p = 32'(signed'(x)) * (net[0] ? 32'sh0000_00B5 : 32'sh0000_0080);
    sh = net >>> 1;
    if (sh >= 0) begin
      p = p <<< sh;
    end else begin
      p = p >>> (-sh);
    end
    p = p >>> 7;
    if (p > 32'sh0000_7FFF) begin
      return 16'h7FFF;
    end else if (p < -32'sh0000_7FFF) begin
      return 16'h8001;
    end
    return p[15:0];
  endfunction

endpackage

// ===== rtl/spk_detector.sv
// power estimator, background noise tracker and two speech comparators
`timescale 1ns/1ns
module spk_detector (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sample_valid,
  input wire logic [15:0] sample_in,
  input wire logic [1:0] ramp_sel,
  input wire logic [4:0] thr_a,
  input wire logic [4:0] thr_b,
  output logic [4:0] power_level,
  output logic [4:0] noise_level,
  output logic speech_a,
  output logic speech_b
);

  typedef struct packed {
    logic [4:0] pe;
    logic [4:0] noise;
    logic [11:0] timer;
    logic sp_a;
    logic sp_b;
  } spk_det_type;

  spk_det_type st_r;
  spk_det_type st_nxt;
  logic [4:0] lvl;
  logic [11:0] ramp_cnt;

  always_comb begin
    st_nxt = st_r;
    lvl = spk_pkg::spk_level(sample_in);
    ramp_cnt = 12'(spk_pkg::RAMP_MS[ramp_sel] * spk_pkg::SAMPLE_HZ / 1000);
    if (sample_valid) begin
      // slewed average keeps single clicks from looking like speech
      if (lvl > st_r.pe) begin
        st_nxt.pe = st_r.pe + 5'h01;
      end else if (lvl < st_r.pe) begin
        st_nxt.pe = st_r.pe - 5'h01;
      end
      if (st_r.pe < st_r.noise) begin
        st_nxt.noise = st_r.pe;
        st_nxt.timer = 12'h000;
      end else if (st_r.pe > st_r.noise) begin
        if (st_r.timer >= ramp_cnt - 12'h001) begin
          st_nxt.noise = st_r.noise + 5'h01;
          st_nxt.timer = 12'h000;
        end else begin
          st_nxt.timer = st_r.timer + 12'h001;
        end
      end else begin
        st_nxt.timer = 12'h000;
      end
      st_nxt.sp_a = {1'b0, st_r.pe} > {1'b0, st_r.noise} + {1'b0, thr_a};
      st_nxt.sp_b = {1'b0, st_r.pe} > {1'b0, st_r.noise} + {1'b0, thr_b};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign power_level = st_r.pe;
  assign noise_level = st_r.noise;
  assign speech_a = st_r.sp_a;
  assign speech_b = st_r.sp_b;

endmodule

// ===== rtl/spk_switch_agc.sv
// half-duplex switching, AGC/volume and echo squelch with an AXI4-Lite slave
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module spk_switch_agc #(
  parameter int AXI_ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic [15:0] tx_in,
  input wire logic [15:0] rx_in,
  input wire logic tone_present,
  input wire logic filter_converged,
  output logic [15:0] tx_out,
  output logic [15:0] rx_out,
  output logic out_valid,
  output logic coef_clear,
  output logic adapt_hold
);

  if (AXI_ADDR_W < 8) begin : g_chk
    $error("spk_switch_agc: AXI_ADDR_W must be at least 8");
  end

  typedef struct packed {
    logic aw_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0][15:0] ctl;
    spk_pkg::spk_hd_type hd;
    logic [11:0] hold;
    logic hd_active;
    logic near;
    logic [1:0][4:0] att;
    logic [1:0][7:0] dec;
    logic [1:0][15:0] dout;
    logic out_valid;
    logic coef_clear;
    logic adapt_hold;
  } spk_state_type;

  spk_state_type st_r;
  spk_state_type st_nxt;

  // ----------------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------------
  logic [3:0] vol [2];
  logic policy;
  logic idle_ret;
  logic [1:0] ramp_sel;
  logic [4:0] tx_sw_thr;
  logic [4:0] rx_sw_thr;
  logic [4:0] rx_sq_thr;
  logic [11:0] hold_cnt;
  logic [5:0] tx_sq_att;
  logic [5:0] erle_u;
  logic [5:0] bias_u;

  always_comb begin
    vol[0] = st_r.ctl[1][spk_pkg::VOL_LSB +: 4];
    vol[1] = st_r.ctl[0][spk_pkg::VOL_LSB +: 4];
    policy = st_r.ctl[0][spk_pkg::CTL0_POLICY_BIT];
    idle_ret = st_r.ctl[0][spk_pkg::CTL0_IDLE_RET_BIT];
    ramp_sel = st_r.ctl[2][spk_pkg::CTL2_RAMP_LSB +: 2];
    // threshold code 0 is 6 dB, each step adds 3 dB
    tx_sw_thr = spk_pkg::THR_BASE_U + {3'h0, st_r.ctl[1][spk_pkg::CTL1_TX_THR_LSB +: 2]};
    rx_sw_thr = spk_pkg::THR_BASE_U + {3'h0, st_r.ctl[2][spk_pkg::CTL2_RX_THR_LSB +: 2]};
    rx_sq_thr = spk_pkg::THR_BASE_U + {3'h0, st_r.ctl[2][spk_pkg::CTL2_RSQ_THR_LSB +: 2]};
    hold_cnt = 12'(spk_pkg::HOLD_MS[st_r.ctl[2][spk_pkg::CTL2_HOLD_LSB +: 2]]
               * spk_pkg::SAMPLE_HZ / 1000);
    tx_sq_att = 6'(2) * ({4'h0, st_r.ctl[3][spk_pkg::CTL3_TX_SQUELCH_ATTENUATION_LSB +: 2]} + 6'h01);
    erle_u = spk_pkg::ERLE_BASE_U + {4'h0, st_r.ctl[3][spk_pkg::CTL3_ERLE_LSB +: 2]};
    bias_u = spk_pkg::BIAS_BASE_U + {4'h0, st_r.ctl[3][spk_pkg::CTL3_BIAS_LSB +: 2]};
  end

  // ----------------------------------------------------------------------------
  // speech detectors
  // ----------------------------------------------------------------------------
  logic [4:0] tx_pe;
  logic [4:0] tx_noise;
  logic [4:0] rx_pe;
  logic [4:0] rx_noise;
  logic tx_sw_speech;
  logic tx_sq_speech;
  logic rx_sw_speech;
  logic rx_sq_speech;

  spk_detector u_tx_det (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sample_valid(sample_valid),
    .sample_in(tx_in),
    .ramp_sel(ramp_sel),
    .thr_a(tx_sw_thr),
    .thr_b(spk_pkg::TX_SQ_THR_U),
    .power_level(tx_pe),
    .noise_level(tx_noise),
    .speech_a(tx_sw_speech),
    .speech_b(tx_sq_speech)
  );

  spk_detector u_rx_det (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sample_valid(sample_valid),
    .sample_in(rx_in),
    .ramp_sel(ramp_sel),
    .thr_a(rx_sw_thr),
    .thr_b(rx_sq_thr),
    .power_level(rx_pe),
    .noise_level(rx_noise),
    .speech_a(rx_sw_speech),
    .speech_b(rx_sq_speech)
  );

  // ----------------------------------------------------------------------------
  // squelch decisions
  // ----------------------------------------------------------------------------
  logic near_nxt;
  logic tx_sq_on;
  logic rx_sq_on;

  always_comb begin
    // echo sits erle below far-end power; bias eases staying released
    near_nxt = tx_sq_speech && ({1'b0, tx_pe} + (st_r.near ? bias_u : erle_u)
               > {1'b0, rx_pe});
    if (policy) begin
      tx_sq_on = rx_sq_speech && !st_r.near;
    end else begin
      tx_sq_on = !st_r.near;
    end
    tx_sq_on = tx_sq_on && !tone_present;
    rx_sq_on = !rx_sq_speech && !tone_present;
  end

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  logic [31:0] rd_word;
  logic rd_hit;
  logic [AXI_ADDR_W-1:0] ra;

  always_comb begin
    ra = s_axi_araddr;
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    if (ra == AXI_ADDR_W'(spk_pkg::ADDR_CTL0)) begin
      rd_word = {16'h0000, st_r.ctl[0]};
    end else if (ra == AXI_ADDR_W'(spk_pkg::ADDR_CTL1)) begin
      rd_word = {16'h0000, st_r.ctl[1]};
    end else if (ra == AXI_ADDR_W'(spk_pkg::ADDR_CTL2)) begin
      rd_word = {16'h0000, st_r.ctl[2]};
    end else if (ra == AXI_ADDR_W'(spk_pkg::ADDR_CTL3)) begin
      rd_word = {16'h0000, st_r.ctl[3]};
    end else if (ra == AXI_ADDR_W'(spk_pkg::ADDR_STATUS)) begin
      rd_word = {23'h00_0000, st_r.near, rx_sq_on, tx_sq_on, rx_sw_speech, tx_sw_speech,
                 st_r.hd_active, st_r.hd};
    end else if (ra == AXI_ADDR_W'(spk_pkg::ADDR_LEVELS)) begin
      rd_word = {12'h000, rx_noise, rx_pe, tx_noise, tx_pe};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  logic [AXI_ADDR_W-1:0] wa;
  logic [1:0] widx;
  logic wr_hit;
  logic [15:0] smp [2];
  logic [4:0] lvl;
  logic signed [6:0] gain;
  logic signed [6:0] net;
  logic [5:0] thr;
  logic [5:0] sq;
  logic mute;

  always_comb begin
    st_nxt = st_r;
    wa = st_r.aw_addr;
    widx = 2'h0;
    wr_hit = 1'b1;
    smp[0] = tx_in;
    smp[1] = rx_in;
    lvl = 5'h00;
    gain = 7'sh00;
    net = 7'sh00;
    thr = 6'h00;
    sq = 6'h00;
    mute = 1'b0;
    st_nxt.coef_clear = 1'b0;
    st_nxt.adapt_hold = tone_present;
    st_nxt.out_valid = 1'b0;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      if (wa == AXI_ADDR_W'(spk_pkg::ADDR_CTL0)) begin
        widx = 2'h0;
      end else if (wa == AXI_ADDR_W'(spk_pkg::ADDR_CTL1)) begin
        widx = 2'h1;
      end else if (wa == AXI_ADDR_W'(spk_pkg::ADDR_CTL2)) begin
        widx = 2'h2;
      end else if (wa == AXI_ADDR_W'(spk_pkg::ADDR_CTL3)) begin
        widx = 2'h3;
      end else begin
        wr_hit = 1'b0;
      end
      if (wr_hit) begin
        if (st_r.w_strb[0]) begin
          st_nxt.ctl[widx][7:0] = st_r.w_data[7:0];
        end
        if (st_r.w_strb[1]) begin
          st_nxt.ctl[widx][15:8] = st_r.w_data[15:8];
        end
      end
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_hit ? spk_pkg::RESP_OKAY : spk_pkg::RESP_SLVERR;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = rd_hit ? spk_pkg::RESP_OKAY : spk_pkg::RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // half-duplex ends for good once the cancellers have adapted
    if (filter_converged) begin
      st_nxt.hd_active = 1'b0;
    end

    if (sample_valid) begin
      st_nxt.near = near_nxt;
      st_nxt.out_valid = 1'b1;
      case (st_r.hd)
        spk_pkg::HD_TX: begin
          if (tx_sw_speech) begin
            st_nxt.hold = hold_cnt;
          end else if (st_r.hold == 12'h000) begin
            st_nxt.hd = spk_pkg::HD_IDLE;
          end else begin
            st_nxt.hold = st_r.hold - 12'h001;
          end
        end
        spk_pkg::HD_RX: begin
          if (rx_sw_speech) begin
            st_nxt.hold = hold_cnt;
          end else if (st_r.hold == 12'h000) begin
            st_nxt.hd = spk_pkg::HD_IDLE;
          end else begin
            st_nxt.hold = st_r.hold - 12'h001;
          end
        end
        default: begin
          st_nxt.hold = hold_cnt;
          if (tx_sw_speech) begin
            st_nxt.hd = spk_pkg::HD_TX;
          end else if (rx_sw_speech) begin
            st_nxt.hd = spk_pkg::HD_RX;
          end else if (idle_ret && st_r.hd_active) begin
            st_nxt.hd = spk_pkg::HD_TX;
          end
        end
      endcase

      // path 0 transmit, path 1 receive
      for (int p = 0; p < 2; p++) begin
        lvl = spk_pkg::spk_level(smp[p]);
        gain = 7'(spk_pkg::GAIN_MAX_U) - 7'({3'h0, vol[p]});
        thr = {1'b0, spk_pkg::LVL_FS} - 6'(gain);
        if (gain > 7'sh00) begin
          if ({1'b0, lvl} > thr + {1'b0, st_r.att[p]}) begin
            // one sample covers the attack time
            st_nxt.att[p] = 5'(({1'b0, lvl} - thr));
            st_nxt.dec[p] = 8'h00;
          end else if (st_r.dec[p] >= spk_pkg::DECAY_SMP - 8'h01) begin
            st_nxt.dec[p] = 8'h00;
            if (st_r.att[p] != 5'h00) begin
              st_nxt.att[p] = st_r.att[p] - 5'h01;
            end
          end else begin
            st_nxt.dec[p] = st_r.dec[p] + 8'h01;
          end
        end else begin
          st_nxt.att[p] = 5'h00;
          st_nxt.dec[p] = 8'h00;
        end
        if (p == 0) begin
          sq = tx_sq_on ? tx_sq_att : 6'h00;
          mute = st_r.hd_active && (st_r.hd == spk_pkg::HD_RX) && !tone_present;
        end else begin
          sq = rx_sq_on ? spk_pkg::RX_SQ_U : 6'h00;
          mute = st_r.hd_active && (st_r.hd == spk_pkg::HD_TX) && !tone_present;
        end
        // gain applied after limiting lifts the reference to full scale
        net = gain - 7'({2'h0, st_nxt.att[p]}) - 7'({1'b0, sq});
        if (mute || vol[p] == spk_pkg::VOL_MUTE) begin
          st_nxt.dout[p] = 16'h0000;
        end else begin
          st_nxt.dout[p] = spk_pkg::spk_scale(smp[p], net);
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.ctl[0] <= spk_pkg::CTL0_RST;
      st_r.ctl[1] <= spk_pkg::CTL1_RST;
      st_r.ctl[2] <= spk_pkg::CTL2_RST;
      st_r.ctl[3] <= spk_pkg::CTL3_RST;
      st_r.hd <= spk_pkg::HD_IDLE;
      st_r.hd_active <= 1'b1;
      st_r.coef_clear <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign tx_out = st_r.dout[0];
  assign rx_out = st_r.dout[1];
  assign out_valid = st_r.out_valid;
  assign coef_clear = st_r.coef_clear;
  assign adapt_hold = st_r.adapt_hold;

endmodule

// ===== testbench/spk_switch_agc_chk.sv
// port-level assertions for the speakerphone switch, AGC and squelch block
`timescale 1ns/1ns
module spk_switch_agc_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic tone_present,
  input wire logic [15:0] tx_out,
  input wire logic [15:0] rx_out,
  input wire logic out_valid,
  input wire logic coef_clear,
  input wire logic adapt_hold
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_coef_clear_done: assert property ($past(rst_b) |-> !coef_clear)
    else $error("coef_clear high after reset release");
  a_tone_holds_adapt: assert property (tone_present |=> adapt_hold)
    else $error("adapt_hold missing while tone present");
  a_tone_frees_adapt: assert property (!tone_present |=> !adapt_hold)
    else $error("adapt_hold stuck without tone");
  a_out_one_shot: assert property (sample_valid |=> out_valid ##1 !out_valid)
    else $error("out_valid not a single pulse after sample");
  a_out_has_cause: assert property (out_valid |-> $past(sample_valid))
    else $error("out_valid without sample");
  a_out_stands: assert property (!out_valid |-> $stable(tx_out) && $stable(rx_out))
    else $error("outputs moved between samples");
  a_write_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late or early");
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_bvalid_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after handshake");
  a_rvalid_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held after handshake");
endmodule

bind spk_switch_agc spk_switch_agc_chk u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sample_valid(sample_valid), .tone_present(tone_present), .tx_out(tx_out),
  .rx_out(rx_out), .out_valid(out_valid), .coef_clear(coef_clear), .adapt_hold(adapt_hold)
);

// ===== testbench/spk_conv_model.sv
// converter-side stand-in: sample strobes out, processed samples captured
`timescale 1ns/1ns
module spk_conv_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [15:0] tx_val,
  input wire logic [15:0] rx_val,
  input wire logic out_valid,
  input wire logic [15:0] tx_out,
  input wire logic [15:0] rx_out,
  output logic sample_valid,
  output logic [15:0] tx_in,
  output logic [15:0] rx_in,
  output logic [15:0] cap_tx,
  output logic [15:0] cap_rx,
  output logic [7:0] cap_cnt
);
  logic [1:0] phase_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 2'h0;
      sample_valid <= 1'b0;
      tx_in <= 16'h0000;
      rx_in <= 16'h0000;
      cap_tx <= 16'h0000;
      cap_rx <= 16'h0000;
      cap_cnt <= 8'h00;
    end else begin
      phase_r <= phase_r + 2'h1;
      sample_valid <= (phase_r == 2'h3);
      // lines toggle between strobes so a stale sample is never mistaken for live
      tx_in <= (phase_r == 2'h3) ? tx_val : ~tx_in;
      rx_in <= (phase_r == 2'h3) ? rx_val : ~rx_in;
      if (out_valid) begin
        cap_tx <= tx_out;
        cap_rx <= rx_out;
        cap_cnt <= cap_cnt + 8'h01;
      end
    end
  end
endmodule

// ===== testbench/spk_switch_agc_bench.sv
// self-checking bench for the speakerphone switch, AGC and squelch block
`timescale 1ns/1ns
module spk_switch_agc_bench;
  logic sys_clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, tone = 1'b0, conv = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [15:0] tx_val = 16'h0000, rx_val = 16'h0000;
  logic awready, wready, bvalid, arready, rvalid, sample_valid, out_valid, coef_clear;
  logic adapt_hold;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] tx_in, rx_in, tx_out, rx_out, cap_tx, cap_rx;
  logic [7:0] cap_cnt;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #2 sys_clk = ~sys_clk;
  spk_switch_agc u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_valid(sample_valid), .tx_in(tx_in), .rx_in(rx_in), .tone_present(tone),
    .filter_converged(conv), .tx_out(tx_out), .rx_out(rx_out), .out_valid(out_valid),
    .coef_clear(coef_clear), .adapt_hold(adapt_hold)
  );
  spk_conv_model u_conv (
    .sys_clk(sys_clk), .rst_b(rst_b), .tx_val(tx_val), .rx_val(rx_val), .out_valid(out_valid),
    .tx_out(tx_out), .rx_out(rx_out), .sample_valid(sample_valid), .tx_in(tx_in),
    .rx_in(rx_in), .cap_tx(cap_tx), .cap_rx(cap_rx), .cap_cnt(cap_cnt)
  );
  // --------------------------------------------------------------------------
  // reporting and bus tasks
  // --------------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // second capture after the change is the first sure to be built from the new values
  task automatic smp(input logic [15:0] t, input logic [15:0] r);
    logic [7:0] n;
    @(posedge sys_clk);
    tx_val <= t;
    rx_val <= r;
    n = cap_cnt + 8'h02;
    while (cap_cnt !== n) @(posedge sys_clk);
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] a [5];
    logic [31:0] e [5];
    a = '{spk_pkg::ADDR_CTL0, spk_pkg::ADDR_CTL1, spk_pkg::ADDR_CTL2, spk_pkg::ADDR_CTL3,
          spk_pkg::ADDR_STATUS};
    e = '{32'h0000_0A00, 32'h0000_0A00, 32'h0000_0000, 32'h0000_0000, 32'h0000_0009};
    for (int i = 0; i < 5; i++) begin
      rd(a[i], d, r);
      chk("reset_value", e[i], (i == 4) ? d & 32'h0000_000F : d);
    end
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    wr(spk_pkg::ADDR_CTL2, 32'h0000_FF00, 4'hF, r);
    rd(spk_pkg::ADDR_CTL2, d, r);
    chk("ctl2", 32'h0000_FF00, d);
    wr(spk_pkg::ADDR_CTL3, 32'hFFFF_C0F0, 4'hF, r);
    wr(spk_pkg::ADDR_CTL3, 32'h0000_1234, 4'h1, r);
    rd(spk_pkg::ADDR_CTL3, d, r);
    chk("ctl3", 32'h0000_C034, d);
    wr(spk_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF, r);
    chk("ro_bresp", {30'h0, spk_pkg::RESP_SLVERR}, {30'h0, r});
    rd(8'h18, d, r);
    chk("hole_rresp", {30'h0, spk_pkg::RESP_SLVERR}, {30'h0, r});
  endtask
  // tone open path: 0 dB at code 10, then 6 dB per two codes, mute at 15
  task automatic t_vol();
    logic [1:0] r;
    logic [15:0] e;
    logic [3:0] c [4];
    c = '{4'hA, 4'hC, 4'hE, 4'hF};
    tone <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(spk_pkg::ADDR_CTL0, {20'h0, c[i], 8'h00}, 4'hF, r);
      wr(spk_pkg::ADDR_CTL1, {20'h0, c[i], 8'h00}, 4'hF, r);
      smp(16'h1000, 16'hF000);
      e = (c[i] == 4'hF) ? 16'h0000 : 16'h1000 >> ((c[i] - 4'hA) / 2);
      chk("tx_gain", {16'h0, e}, {16'h0, cap_tx});
      chk("rx_gain", {16'h0, 16'h0000 - e}, {16'h0, cap_rx});
    end
    smp(16'h0000, 16'h0000);
    tone <= 1'b0;
  endtask
  task automatic t_hd();
    logic [31:0] d;
    logic [1:0] r;
    wr(spk_pkg::ADDR_CTL0, 32'h0000_0A01, 4'hF, r);
    smp(16'h0000, 16'h0000);
    smp(16'h0000, 16'h0000);
    rd(spk_pkg::ADDR_STATUS, d, r);
    chk("idle_to_tx", 32'h0000_000A, d & 32'h0000_000F);
    smp(16'h0000, 16'h2000);
    chk("rx_muted", 32'h0000_0000, {16'h0, cap_rx});
    conv <= 1'b1;
    @(posedge sys_clk);
    conv <= 1'b0;
    rd(spk_pkg::ADDR_STATUS, d, r);
    chk("hd_off", 32'h0000_0000, d & 32'h0000_0008);
    smp(16'h0000, 16'h0000);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    chk("coef_clear", 32'h0000_0001, {31'h0, coef_clear});
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_vol();
    // fresh detectors, so only idle-return can move idle to transmit
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("coef_clear", 32'h0000_0001, {31'h0, coef_clear});
    rst_b <= 1'b1;
    t_reset();
    t_hd();
    end_sim();
  end
endmodule
